// [eth_media_access_unit.sv]
// Purpose: Media interface of the Ethernet MAC toward an external transceiver.
// Assumes: Link clocks are sampled by ref_clk_in; 1000 Mbps data uses the link clocks
//          through an external capture stage, this block times the qualifiers.
// Notes: No software registers; configuration arrives on plain inputs.
`timescale 1ns/10ps
`default_nettype none
module eth_media_access_unit
#(
    parameter int RST_CYC = media_pkg::PHY_RST_CYC,
    parameter int WAIT_CYC = media_pkg::PHY_WAIT_CYC
)
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire media_pkg::media_mode_t mode_in,
    input wire media_pkg::speed_t speed_in,
    input wire logic full_duplex_in,
    input wire logic [47:0] station_addr_in,
    input wire logic tx_valid_in,
    input wire logic [3:0] tx_data_in,
    input wire logic tx_err_in,
    input wire logic mgmt_start_in,
    input wire logic [31:0] mgmt_frame_in,
    input wire logic tx_clk_in,
    input wire logic rx_clk_in,
    input wire logic [3:0] rx_data_in,
    input wire logic rx_valid_in,
    input wire logic rx_error_in,
    input wire logic carrier_sense_in,
    input wire logic collision_in,
    input wire logic mdio_in,
    output logic [3:0] tx_data_out,
    output logic tx_enable_out,
    output logic tx_error_out,
    output logic mdc_out,
    output logic mdio_out,
    output logic mdio_oe_n_out,
    output logic phy_reset_n_out,
    output logic phy_clk_en_out,
    output logic link_ready_out,
    output logic tx_ready_out,
    output logic [3:0] rx_data_out,
    output logic rx_valid_out,
    output logic rx_err_out,
    output logic crs_out,
    output logic col_out,
    output logic [15:0] mgmt_rdata_out,
    output logic mgmt_busy_out
);
    import media_pkg::*;
    // Bring-up counts must be at least one cycle each
    if (RST_CYC < 1 || WAIT_CYC < 1)
    begin : g_count_check
        $error("Bad bring-up counts");
    end

    // =====================================================================
    // Input synchronisers
    // =====================================================================
    localparam int SW = 12;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [1:0] clk_hist_q;
    wire [SW-1:0] pins = {tx_clk_in, rx_clk_in, rx_data_in, rx_valid_in, rx_error_in,
        carrier_sense_in, collision_in, mdio_in, 1'b0};
    // Two-stage capture of pin inputs
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            s1_q <= '0;
            s2_q <= '0;
            clk_hist_q <= 2'h0;
        end
        else if (ce_in)
        begin
            s1_q <= pins;
            s2_q <= s1_q;
            clk_hist_q <= s2_q[11:10];
        end
    end
    wire tx_clk_s = s2_q[11];
    wire rx_clk_s = s2_q[10];
    wire [3:0] rxd_s = s2_q[9:6];
    wire rxdv_s = s2_q[5];
    wire rxer_s = s2_q[4];
    wire crs_s = s2_q[3];
    wire col_s = s2_q[2];
    wire mdio_s = s2_q[1];
    wire tx_rise = tx_clk_s && !clk_hist_q[1];
    wire rx_rise = rx_clk_s && !clk_hist_q[0];
    wire rx_fall = !rx_clk_s && clk_hist_q[0];

    // =====================================================================
    // Transceiver bring-up sequence
    // =====================================================================
    bring_t st_q;
    bring_t st_d;
    logic [31:0] cnt_q;
    wire cnt_done_rst = (cnt_q >= 32'(RST_CYC - 1));
    wire cnt_done_wait = (cnt_q >= 32'(WAIT_CYC - 1));
    // Reset held, released, then clock enabled
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_RESET: if (cnt_done_rst) st_d = ST_RELEASE;
            ST_RELEASE: if (cnt_done_wait) st_d = ST_CLOCK;
            ST_CLOCK: if (cnt_done_wait) st_d = ST_RUN;
            ST_RUN: st_d = ST_RUN;
            default: st_d = ST_RESET;
        endcase
    end
    // State register and dwell counter
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            st_q <= ST_RESET;
            cnt_q <= 32'h0;
        end
        else if (ce_in)
        begin
            st_q <= st_d;
            cnt_q <= (st_d != st_q) ? 32'h0 : cnt_q + 32'h1;
        end
    end

    // =====================================================================
    // Mode decode
    // =====================================================================
    wire is_mii = (mode_in == MODE_MII);
    wire is_rmii = (mode_in == MODE_RMII);
    wire is_rg = (mode_in == MODE_RGMII);
    wire spd_ok = is_rg ? (speed_in == SPD_1000)
        : (speed_in == SPD_10 || speed_in == SPD_100);
    wire addr_ok = (station_addr_in != ADDR_RESET) && !station_addr_in[40];
    wire run = (st_q == ST_RUN) && addr_ok && spd_ok && (full_duplex_in || !is_rg);
    wire tx_edge = is_rmii ? 1'b1 : tx_rise;
    wire [3:0] tx_mask = is_rmii ? 4'h3 : 4'hF;

    // =====================================================================
    // Transmit path
    // =====================================================================
    // Transmit outputs idle unless running; while running the pins update on a transmit edge and hold; tx_ready_out marks each edge and stays high in RMII
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            tx_data_out <= 4'h0;
            tx_enable_out <= 1'b0;
            tx_error_out <= 1'b0;
            tx_ready_out <= 1'b0;
        end
        else if (ce_in)
        begin
            tx_ready_out <= run && tx_edge;
            if (!run)
            begin
                tx_data_out <= 4'h0;
                tx_enable_out <= 1'b0;
                tx_error_out <= 1'b0;
            end
            else if (tx_edge)
            begin
                tx_data_out <= tx_data_in & tx_mask;
                tx_enable_out <= tx_valid_in;
                tx_error_out <= is_mii && tx_err_in;
            end
        end
    end

    // =====================================================================
    // Receive path
    // =====================================================================
    logic dv_rise_q;
    wire rx_edge = is_rmii ? 1'b1 : (is_rg ? rx_fall : rx_rise);
    wire rg_err = dv_rise_q ^ rxdv_s;
    wire crs_d = is_mii ? crs_s : (rxdv_s || (is_rg && dv_rise_q));
    // Receive sampling per mode
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            dv_rise_q <= 1'b0;
            rx_data_out <= 4'h0;
            rx_valid_out <= 1'b0;
            rx_err_out <= 1'b0;
            crs_out <= 1'b0;
            col_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (is_rg && rx_rise)
                dv_rise_q <= rxdv_s;
            if (!run)
            begin
                rx_data_out <= 4'h0;
                rx_valid_out <= 1'b0;
                rx_err_out <= 1'b0;
                crs_out <= 1'b0;
                col_out <= 1'b0;
            end
            else if (rx_edge)
            begin
                rx_data_out <= rxd_s & tx_mask;
                rx_valid_out <= is_rg ? dv_rise_q : rxdv_s;
                rx_err_out <= is_rg ? rg_err : rxer_s;
                crs_out <= crs_d;
                col_out <= is_mii && col_s;
            end
        end
    end

    // =====================================================================
    // Management interface
    // =====================================================================
    media_if mi ();
    assign mi.start = mgmt_start_in && (st_q == ST_RUN);
    assign mi.frame = mgmt_frame_in;
    assign mi.mdio_i = mdio_s;
    mgmt_serial #(.DIV(MDC_DIV)) u_mgmt (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .ce_in(ce_in), .m(mi.engine));
    // Registered management pins and bring-up outputs
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            mdc_out <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe_n_out <= 1'b1;
            phy_reset_n_out <= 1'b0;
            phy_clk_en_out <= 1'b0;
            link_ready_out <= 1'b0;
            mgmt_rdata_out <= 16'h0;
            mgmt_busy_out <= 1'b0;
        end
        else if (ce_in)
        begin
            mdc_out <= mi.mdc;
            mdio_out <= mi.mdio_o;
            mdio_oe_n_out <= mi.mdio_oe_n;
            phy_reset_n_out <= (st_d != ST_RESET);
            phy_clk_en_out <= (st_d == ST_CLOCK) || (st_d == ST_RUN);
            link_ready_out <= run;
            mgmt_rdata_out <= mi.rdata;
            mgmt_busy_out <= mi.busy;
        end
    end
endmodule
`default_nettype wire

// [eth_media_access_unit_asserts.sv]
// Purpose: Port-level checks for the media interface block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module media_checker
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire media_pkg::media_mode_t mode_in,
    input wire media_pkg::speed_t speed_in,
    input wire logic full_duplex_in,
    input wire logic [47:0] station_addr_in,
    input wire logic mgmt_start_in,
    input wire logic [3:0] tx_data_out,
    input wire logic tx_enable_out,
    input wire logic tx_error_out,
    input wire logic mdio_oe_n_out,
    input wire logic phy_reset_n_out,
    input wire logic phy_clk_en_out,
    input wire logic link_ready_out,
    input wire logic tx_ready_out,
    input wire logic rx_valid_out,
    input wire logic mgmt_busy_out
);
    import media_pkg::*;
    // ====
    // Defaults and sequences
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence mgmt_req;
        mgmt_start_in && !mgmt_busy_out && link_ready_out;
    endsequence
    sequence busy_run;
        mgmt_busy_out [*8];
    endsequence
    // ====
    // Assertions
    reset_idle_a: assert property (disable iff (1'h0) !$past(rst_n_in) && $past(ce_in)
        |-> !phy_reset_n_out && mdio_oe_n_out && !link_ready_out && !tx_enable_out)
        else $error("outputs not idle after reset");
    clk_after_rel_a: assert property (phy_clk_en_out |-> phy_reset_n_out)
        else $error("transceiver clock on while in reset");
    rel_order_a: assert property ($rose(phy_clk_en_out) |-> $past(phy_reset_n_out, 2))
        else $error("clock enabled too soon after reset release");
    ready_addr_a: assert property (link_ready_out |-> $past(station_addr_in) != 48'h0
        && !$past(station_addr_in[40])) else $error("ready without legal address");
    giga_duplex_a: assert property (link_ready_out && $past(speed_in) == SPD_1000
        |-> $past(full_duplex_in)) else $error("gigabit ready in half duplex");
    idle_quiet_a: assert property (!link_ready_out && !$past(link_ready_out)
        |-> !tx_enable_out && !rx_valid_out && !tx_ready_out) else $error("traffic while idle");
    rmii_narrow_a: assert property (mode_in == MODE_RMII && $past(mode_in) == MODE_RMII
        && $past(mode_in, 2) == MODE_RMII |-> tx_data_out[3:2] == 2'h0 && !tx_error_out)
        else $error("wide transmit in reduced mode");
    err_mii_only_a: assert property ($rose(tx_error_out) |-> $past(mode_in) == MODE_MII)
        else $error("transmit error outside full mode");
    mgmt_answer_a: assert property (mgmt_req |-> ##2 busy_run)
        else $error("management start not answered");
    mdio_release_a: assert property (!mgmt_busy_out && !$past(mgmt_busy_out)
        |-> mdio_oe_n_out) else $error("management line driven while idle");
    mii_tx_pulse_a: assert property (tx_ready_out && mode_in == MODE_MII |=> !tx_ready_out)
        else $error("transmit accept longer than one cycle");
endmodule
bind eth_media_access_unit media_checker chk (.*);
`default_nettype wire

// [eth_media_access_unit_test.sv]
// Purpose: Self-checking bench for the media interface block.
// Assumes: Short bring-up counts of 4 and 2 cycles.
// Notes: Inputs change 2 ns after the rising edge.
`timescale 1ns/10ps
`default_nettype none
module eth_media_access_unit_test;
    import media_pkg::*;
    logic ref_clk_in, rst_n_in, ce_in, full_duplex_in, tx_valid_in, tx_err_in, mgmt_start_in;
    media_mode_t mode_in;
    speed_t speed_in;
    logic [47:0] station_addr_in;
    logic [31:0] mgmt_frame_in;
    logic [3:0] tx_data_in, rx_data_in, tx_data_out, rx_data_out;
    logic tx_clk_in, rx_clk_in, rx_valid_in, rx_error_in, carrier_sense_in, collision_in, mdio_in;
    logic tx_enable_out, tx_error_out, mdc_out, mdio_out, mdio_oe_n_out, phy_reset_n_out;
    logic phy_clk_en_out, link_ready_out, tx_ready_out, rx_valid_out, rx_err_out, crs_out;
    logic col_out, mgmt_busy_out, clk_on, ddr, dv, answer_low;
    logic [15:0] mgmt_rdata_out;
    int err_total, cmp_count, cycles;
    eth_media_access_unit #(.RST_CYC(4), .WAIT_CYC(2)) dut (.*);
    phy_model pm (.clk_on_in(clk_on), .ddr_in(ddr), .dv_in(dv), .er_in(rx_error_in),
        .mdio_d_in(mdio_out), .mdio_oe_n_in(mdio_oe_n_out), .answer_low_in(answer_low),
        .tx_clk_out(tx_clk_in), .rx_clk_out(rx_clk_in), .rx_valid_out(rx_valid_in),
        .mdio_line_out(mdio_in));
    // ====
    // Clock and hang guard
    initial
    begin
        ref_clk_in = 1'h0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            finish_test();
        end
    end
    // ====
    // Shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_hi(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'h1 && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ====
    // Scenarios
    task automatic t_bringup();
        int n;
        wait_hi(phy_reset_n_out, 100, n);
        check("reset_hold", 1, n >= 4);
        check("clk_en_early", 0, phy_clk_en_out);
        wait_hi(phy_clk_en_out, 100, n);
        check("clk_en_gap", 1, n >= 2);
        cyc(20);
        check("ready_no_addr", 0, link_ready_out);
    endtask
    task automatic t_config();
        int n;
        station_addr_in = 48'h0100_0000_0002;
        cyc(20);
        check("ready_multicast", 0, link_ready_out);
        station_addr_in = 48'h0200_0000_0002;
        mode_in = MODE_RGMII;
        speed_in = SPD_1000;
        full_duplex_in = 1'h0;
        cyc(20);
        check("ready_half_giga", 0, link_ready_out);
        full_duplex_in = 1'h1;
        wait_hi(link_ready_out, 100, n);
        check("ready_legal", 1, link_ready_out);
    endtask
    task automatic t_mii_tx();
        int n;
        mode_in = MODE_MII;
        speed_in = SPD_100;
        {tx_valid_in, tx_data_in, tx_err_in} = {1'h1, 4'hA, 1'h1};
        cyc(20);
        wait_hi(tx_enable_out, 40, n);
        check("mii_tx", 16'h35, {tx_enable_out, tx_data_out, tx_error_out});
        clk_on = 1'h0;
        cyc(20);
        tx_data_in = 4'h5;
        cyc(40);
        check("tx_no_clock", 16'hA, tx_data_out);
        clk_on = 1'h1;
    endtask
    task automatic t_rmii();
        mode_in = MODE_RMII;
        tx_data_in = 4'hF;
        {dv, rx_data_in, carrier_sense_in, collision_in} = {1'h1, 4'hF, 1'h0, 1'h1};
        cyc(12);
        check("rmii_tx", 16'h6, {tx_data_out, tx_error_out});
        check("rmii_rx", 16'h1E, {rx_data_out, rx_valid_out, crs_out, col_out});
        check("rmii_ready", 1, tx_ready_out);
        ce_in = 1'h0;
        dv = 1'h0;
        cyc(12);
        check("ce_freeze", 1, crs_out);
        ce_in = 1'h1;
        cyc(12);
        check("rmii_crs_off", 0, crs_out);
    endtask
    task automatic t_mii_rx();
        mode_in = MODE_MII;
        tx_err_in = 1'h0;
        {dv, rx_data_in, rx_error_in, carrier_sense_in} = {1'h1, 4'h5, 1'h1, 1'h1};
        cyc(30);
        check("mii_rx", 16'h5F, {rx_data_out, rx_valid_out, rx_err_out, crs_out, col_out});
        rx_error_in = 1'h0;
    endtask
    task automatic t_giga();
        mode_in = MODE_RGMII;
        speed_in = SPD_1000;
        {ddr, tx_data_in} = 5'h1C;
        for (int k = 1; k < 4; k++)
        begin
            {dv, rx_error_in} = k[1:0];
            cyc(30);
            check("giga_rx", k[1:0], {rx_valid_out, rx_err_out});
        end
        check("giga_tx", 16'h18, {tx_data_out, tx_error_out});
    endtask
    task automatic t_mgmt();
        int n;
        logic rel, mc, lo;
        for (int i = 0; i < 2; i++)
        begin
            {answer_low, rel, mc, lo} = {i[0], 3'h0};
            n = 0;
            mgmt_frame_in = 32'h6082_0000;
            mgmt_start_in = 1'h1;
            cyc(1);
            mgmt_start_in = 1'h0;
            cyc(2);
            check("mgmt_busy", 1, mgmt_busy_out);
            while (mgmt_busy_out === 1'h1 && n < 1200)
            begin
                rel |= mdio_oe_n_out;
                mc |= mdc_out;
                lo |= !mdio_out && !mdio_oe_n_out;
                cyc(1);
                n++;
            end
            check("mgmt_lines", 16'h7, {rel, mc, lo});
            check("mgmt_rdata", i ? 16'h0000 : 16'hFFFF, mgmt_rdata_out);
        end
    endtask
    // ====
    // Main sequence
    initial
    begin
        {rst_n_in, ce_in, full_duplex_in, tx_valid_in, tx_err_in, mgmt_start_in} = 6'h18;
        mode_in = MODE_MII;
        speed_in = SPD_100;
        {station_addr_in, mgmt_frame_in} = 80'h0;
        {tx_data_in, rx_data_in, rx_error_in, carrier_sense_in, collision_in} = 11'h0;
        {clk_on, ddr, dv, answer_low} = 4'h8;
        err_total = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (16) @(posedge ref_clk_in);
        #2;
        rst_n_in = 1'h1;
        t_bringup();
        t_config();
        t_mii_tx();
        t_rmii();
        t_mii_rx();
        t_giga();
        t_mgmt();
        finish_test();
    end
endmodule
`default_nettype wire

// [media_if.sv]
// Purpose: Carries the management serial signals between top and engine.
// Assumes: Single clock domain.
// Notes: Engine drives, top registers onto pins.
`timescale 1ns/10ps
`default_nettype none
interface media_if;
    logic start;
    logic [31:0] frame;
    logic busy;
    logic mdc;
    logic mdio_o;
    logic mdio_oe_n;
    logic mdio_i;
    logic [15:0] rdata;
    modport engine (input start, input frame, input mdio_i, output busy, output mdc,
        output mdio_o, output mdio_oe_n, output rdata);
    modport user (output start, output frame, output mdio_i, input busy, input mdc,
        input mdio_o, input mdio_oe_n, input rdata);
endinterface
`default_nettype wire

// [media_pkg.sv]
// Purpose: Shared constants and types for the Ethernet media interface block.
// Assumes: Block clock ref_clk_in at 40 MHz.
// Notes: Mode, state and timing values live here once.
package media_pkg;
    // =====================================================================
    // Media modes
    // =====================================================================
    typedef enum logic [1:0]
    {
        MODE_MII = 2'h0,
        MODE_RMII = 2'h1,
        MODE_RGMII = 2'h2
    } media_mode_t;

    // =====================================================================
    // Speeds
    // =====================================================================
    typedef enum logic [1:0]
    {
        SPD_10 = 2'h0,
        SPD_100 = 2'h1,
        SPD_1000 = 2'h2
    } speed_t;

    // =====================================================================
    // Transceiver bring-up states
    // =====================================================================
    typedef enum logic [3:0]
    {
        ST_RESET = 4'h1,
        ST_RELEASE = 4'h2,
        ST_CLOCK = 4'h4,
        ST_RUN = 4'h8
    } bring_t;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_HZ = 40000000;
    localparam int PHY_RST_US = 10;
    localparam int PHY_RST_CYC = (PHY_RST_US * (CLK_HZ / 1000000));
    localparam int PHY_WAIT_US = 5;
    localparam int PHY_WAIT_CYC = (PHY_WAIT_US * (CLK_HZ / 1000000));
    localparam int MDC_DIV = 8;
    localparam int DATA_W = 4;
    localparam logic [47:0] ADDR_RESET = 48'h0;
endpackage

// [mgmt_serial.sv]
// Purpose: Management data clock and serial data engine toward the transceiver.
// Assumes: mdio_i already synchronised by the caller.
// Notes: Shifts a 32-bit frame after a 32-bit preamble, MSB first.
`timescale 1ns/10ps
`default_nettype none
module mgmt_serial
#(
    parameter int DIV = media_pkg::MDC_DIV
)
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    media_if.engine m
);
    import media_pkg::*;
    // Divider must fit the 8-bit counter and give two phases
    if (DIV < 2 || DIV > 256)
    begin : g_div_check
        $error("DIV out of range");
    end
    logic [7:0] div_q;
    logic [6:0] bit_q;
    logic [31:0] sh_q;
    logic [15:0] rd_q;
    logic run_q;
    logic mdc_q;
    wire tick = (div_q == 8'(DIV - 1));
    wire rise = tick && !mdc_q;
    wire in_pre = (bit_q < 7'd32);
    wire turn = (bit_q >= 7'd46) && (bit_q < 7'd48);
    wire rd_op = (m.frame[29:28] == 2'h2);
    // Clock divider, shift and sample on rising edges
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            div_q <= 8'h0;
            bit_q <= 7'h0;
            sh_q <= 32'h0;
            rd_q <= 16'h0;
            run_q <= 1'b0;
            mdc_q <= 1'b0;
        end
        else if (ce_in)
        begin
            div_q <= tick ? 8'h0 : div_q + 8'h1;
            if (!run_q && m.start)
            begin
                run_q <= 1'b1;
                sh_q <= m.frame;
                bit_q <= 7'h0;
            end
            else if (run_q && tick)
            begin
                mdc_q <= !mdc_q;
                if (rise)
                begin
                    if (!in_pre)
                    begin
                        sh_q <= {sh_q[30:0], 1'b0};
                        rd_q <= {rd_q[14:0], m.mdio_i};
                    end
                    bit_q <= bit_q + 7'h1;
                    if (bit_q == 7'd63)
                        run_q <= 1'b0;
                end
            end
        end
    end
    assign m.busy = run_q;
    assign m.mdc = mdc_q;
    assign m.mdio_o = in_pre ? 1'b1 : sh_q[31];
    assign m.mdio_oe_n = !(run_q && !(rd_op && (turn || bit_q >= 7'd48)));
    assign m.rdata = rd_q;
endmodule
`default_nettype wire

// [phy_model.sv]
// Purpose: Behavioural transceiver facing the media interface.
// Assumes: Link clocks of 200 ns, unrelated in phase to the block clock.
// Notes: Management line is pulled up when released, unless answer_low_in holds it low.
`timescale 1ns/10ps
`default_nettype none
module phy_model
(
    input wire logic clk_on_in,
    input wire logic ddr_in,
    input wire logic dv_in,
    input wire logic er_in,
    input wire logic mdio_d_in,
    input wire logic mdio_oe_n_in,
    input wire logic answer_low_in,
    output logic tx_clk_out,
    output logic rx_clk_out,
    output logic rx_valid_out,
    output logic mdio_line_out
);
    // ====
    // Link clocks; transmit clock can be stopped
    initial
    begin
        tx_clk_out = 1'h0;
        #7.3;
        forever #100 if (clk_on_in) tx_clk_out = ~tx_clk_out;
    end
    initial
    begin
        rx_clk_out = 1'h0;
        #51.1;
        forever #100 rx_clk_out = ~rx_clk_out;
    end
    // Valid on the high phase, valid XOR error on the low phase in gigabit
    always_comb rx_valid_out = (ddr_in && !rx_clk_out) ? (dv_in ^ er_in) : dv_in;
    // Open-drain line: pull-up, or held low when asked to answer zeros
    assign mdio_line_out = !mdio_oe_n_in ? mdio_d_in : !answer_low_in;
endmodule
`default_nettype wire
